// [logic/spr_ctrl.sv]
// self-poll channel scan and run-state control with ahb-lite registers
// Function
// RULE_01 - up to three channels per configuration
// RULE_02 - channel count field bits 3:2
// RULE_03 - slave mode scans only one channel
// RULE_04 - record woken channel code bits 1:0
// RULE_05 - third channel reports code 11b
// RULE_06 - per channel r and s dividers
// RULE_07 - wake-up enters run self-poll state
// RULE_08 - run state sequences frame reception autonomously
// RULE_09 - alert host on start, match, end
// RULE_10 - leave run on sync loss timeout
// RULE_11 - host may command sleep or slave
// RULE_12 - keep receiving later frames in run
// RULE_13 - clear fifo at cycle or frame start
// RULE_14 - cycle-start init when control zero bit7
// RULE_15 - bit5 enables sync timeout timer
// RULE_16 - bit4 locks fifo at end of message
// RULE_17 - locked fifo stops reception and sync
// RULE_18 - frame-start init when control one bit3
// RULE_19 - frame ends at end of message
`timescale 1ns/1ps
module spr_ctrl
	import spr_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire spr_rx_s     rx_pin,
	input  wire logic        fifo_lock_release,
	output spr_tune_s        tune,
	output logic             alert_frame,
	output logic             alert_mid,
	output logic             alert_eom,
	output logic             fifo_out_valid,
	input  wire logic        fifo_out_ready,
	output logic [7:0]       fifo_out_data,
	output logic             fifo_overrun
);
	// registers
	logic [7:0]  cmc_zero;
	logic [7:0]  cmc_one;
	logic [7:0]  modt [2];
	logic [7:0]  pll  [2][MAX_CHANNELS];
	logic [1:0]  woken_channel_code;
	logic [1:0]  mode;
	spr_state_e  state;
	logic        conf_b;
	logic [1:0]  chan;
	logic [15:0] dwell;
	logic [15:0] sync_timeout_timer;
	logic        fifo_locked;
	logic        frame_active;
	logic        fifo_clr;
	// ahb address phase capture
	logic        ph_wr;
	logic [7:0]  ph_idx;
	// synchronised framer inputs
	spr_rx_s     rx_s1;
	spr_rx_s     rx;
	logic        rel_s1;
	logic        rel;
	logic        f_ready;
	logic        f_valid;

	// number of channels for a configuration, floored at one
	function automatic logic [1:0] chan_limit(input logic [7:0] mt, input logic [1:0] md);
		logic [1:0] n;
		n = mt[CNT_HI:CNT_LO];
		if (md == MODE_SLAVE) begin
			n = CNT_MIN; // [RULE_03]
		end else if (n < CNT_MIN) begin
			n = CNT_MIN; // [RULE_02]
		end
		return n;
	endfunction

	// two-flop synchronisers for framer events and lock release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_s1  <= '0;
			rx     <= '0;
			rel_s1 <= 1'b0;
			rel    <= 1'b0;
		end else begin
			rx_s1  <= rx_pin;
			rx     <= rx_s1;
			rel_s1 <= fifo_lock_release;
			rel    <= rel_s1;
		end
	end

	// ahb-lite: always zero wait state, okay response, both from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_wr     <= 1'b0;
			ph_idx    <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			if (hready) begin
				ph_wr  <= hsel && htrans[1] && hwrite;
				ph_idx <= haddr[9:2];
			end
		end
	end

	// writable registers; unmapped writes dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmc_zero <= RST_CMC_ZERO;
			cmc_one  <= RST_CMC_ONE;
			modt[0]  <= RST_MODT;
			modt[1]  <= RST_MODT;
			pll[0][0] <= RST_PLL1;
			pll[0][1] <= RST_PLL2;
			pll[0][2] <= RST_PLL3;
			pll[1][0] <= RST_PLL1;
			pll[1][1] <= RST_PLL2;
			pll[1][2] <= RST_PLL3;
			mode     <= MODE_SLEEP;
		end else if (ph_wr) begin
			case (ph_idx)
				IDX_CMC_ZERO: cmc_zero  <= hwdata[7:0];
				IDX_CMC_ONE:  cmc_one   <= hwdata[7:0];
				IDX_A_MODT:   modt[0]   <= hwdata[7:0];
				IDX_B_MODT:   modt[1]   <= hwdata[7:0];
				IDX_A_PLL1:   pll[0][0] <= hwdata[7:0]; // [RULE_06]
				IDX_A_PLL2:   pll[0][1] <= hwdata[7:0];
				IDX_A_PLL3:   pll[0][2] <= hwdata[7:0];
				IDX_B_PLL1:   pll[1][0] <= hwdata[7:0];
				IDX_B_PLL2:   pll[1][1] <= hwdata[7:0];
				IDX_B_PLL3:   pll[1][2] <= hwdata[7:0];
				IDX_MODE:     mode      <= hwdata[1:0]; // [RULE_11]
				default: ;
			endcase
		end
	end

	// read mux; control registers are write-only and read zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (hsel && htrans[1] && !hwrite && hready) begin
			case (haddr[9:2])
				IDX_WOKEN:  hrdata <= {30'h0, woken_channel_code};
				IDX_STATUS: hrdata <= {24'h0, fifo_locked, state};
				default:    hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// channel scan in self-poll: dwell on each channel, then next channel/config
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			conf_b <= 1'b0;
			chan   <= 2'h0;
			dwell  <= 16'h0000;
		end else if (state == ST_SLEEP || mode == MODE_SLAVE) begin
			// slave wins even mid-scan, so no hop after the mode change
			chan   <= 2'h0; // [RULE_03]
			conf_b <= 1'b0;
			dwell  <= 16'h0000;
		end else if (state == ST_POLL) begin
			if (dwell == 16'(CHAN_DWELL_CYC - 1)) begin
				dwell <= 16'h0000;
				// at most three channels each for a and b
				if (chan + 2'h1 >= chan_limit(modt[conf_b], mode)) begin // [RULE_01]
					chan   <= 2'h0;
					conf_b <= !conf_b;
				end else begin
					chan <= chan + 2'h1;
				end
			end else begin
				dwell <= dwell + 16'h0001;
			end
		end
	end

	// tuning word straight from flops
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tune <= '0;
		end else begin
			tune.conf_b <= conf_b;
			tune.chan   <= chan;
			tune.r_div  <= pll[conf_b][chan][4:2]; // [RULE_06]
			tune.s_div  <= pll[conf_b][chan][1:0];
		end
	end

	// woken channel record: code = index + 1, so third gives 11b
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			woken_channel_code <= 2'h0;
		end else if (state == ST_POLL && rx.wake) begin
			woken_channel_code <= chan + 2'h1; // [RULE_04] [RULE_05]
		end
	end

	// sync timeout: runs while unsynchronised in run state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sync_timeout_timer <= 16'h0000;
		end else if (state == ST_WSYNC && cmc_zero[BIT_TO_EN]) begin // [RULE_15]
			sync_timeout_timer <= sync_timeout_timer + 16'h0001;
		end else begin
			sync_timeout_timer <= 16'h0000;
		end
	end

	// main run-state sequencer; host sleep command always wins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= ST_SLEEP;
		end else if (mode == MODE_SLEEP) begin
			state <= ST_SLEEP; // [RULE_11]
		end else begin
			case (state)
				ST_SLEEP: state <= (mode == MODE_SLAVE) ? ST_INIT : ST_POLL;
				ST_POLL: begin
					if (mode == MODE_SLAVE) begin
						state <= ST_INIT;
					end else if (rx.wake) begin
						state <= ST_INIT; // [RULE_07]
					end
				end
				ST_INIT:  state <= ST_WSYNC; // [RULE_08]
				ST_WSYNC: begin
					if (rx.sync_ok) begin
						state <= ST_WTSI;
					end else if (mode == MODE_SELF && cmc_zero[BIT_TO_EN] &&
						sync_timeout_timer >= 16'(SYNC_TO_CYC - 1)) begin
						state <= ST_POLL; // [RULE_10]
					end
				end
				ST_WTSI: begin
					if (!rx.sync_ok) begin
						state <= ST_WSYNC;
					end else if (rx.frame_start_pattern) begin
						state <= ST_FRAME;
					end
				end
				ST_FRAME: begin
					if (rx.end_of_message) begin
						// back to search unless fifo lock set: later frames still received
						state <= cmc_zero[BIT_FIFO_LOCK] ? ST_LOCK : ST_WSYNC; // [RULE_12] [RULE_16]
					end else if (!rx.sync_ok) begin
						state <= ST_WSYNC;
					end
				end
				ST_LOCK: begin
					if (rel) begin
						state <= ST_WSYNC; // [RULE_17]
					end
				end
				default: state <= ST_SLEEP;
			endcase
		end
	end

	// lock flag mirrors the lock state for status reads
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fifo_locked <= 1'b0;
		end else begin
			fifo_locked <= (state == ST_FRAME && rx.end_of_message && cmc_zero[BIT_FIFO_LOCK]) ||
				(state == ST_LOCK && !rel);
		end
	end

	// fifo clear at cycle start or frame start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fifo_clr <= 1'b0;
		end else begin
			fifo_clr <= (state == ST_INIT && cmc_zero[BIT_INIT_CYCLE]) || // [RULE_13] [RULE_14]
				(state == ST_WTSI && rx.sync_ok && rx.frame_start_pattern &&
				cmc_one[BIT_INIT_FRAME] && mode != MODE_SLEEP); // [RULE_18]
		end
	end

	// frame window from frame start to end of message
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			frame_active <= 1'b0;
		end else begin
			frame_active <= (state == ST_FRAME) && !rx.end_of_message && rx.sync_ok; // [RULE_19]
		end
	end

	// host alerts as single-cycle pulses; masking belongs to the host side
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			alert_frame <= 1'b0;
			alert_mid   <= 1'b0;
			alert_eom   <= 1'b0;
		end else begin
			alert_frame <= state == ST_WTSI && rx.sync_ok && rx.frame_start_pattern; // [RULE_09]
			alert_mid   <= state == ST_FRAME && rx.mid_match;
			alert_eom   <= state == ST_FRAME && rx.end_of_message;
		end
	end

	// overflow flag: bit lost when fifo full, cleared by fifo init
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fifo_overrun <= 1'b0;
		end else if (f_valid && !f_ready) begin
			fifo_overrun <= 1'b1;
		end else if (fifo_clr) begin
			fifo_overrun <= 1'b0;
		end
	end

	// bits only enter the fifo inside a frame, never while locked
	assign f_valid = frame_active && rx.bit_valid && !fifo_locked; // [RULE_17]

	spr_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.clk      (hclk),
		.rst_n    (hresetn),
		.clr      (fifo_clr),
		.in_valid (f_valid),
		.in_ready (f_ready),
		.in_data  ({7'h00, rx.bit_data}),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data (fifo_out_data)
	);

	// checks
	property p_alert_eom;
		@(posedge hclk) disable iff (!hresetn)
		(state == ST_FRAME && rx.end_of_message) |=> alert_eom;
	endproperty
	a_alert_eom: assert property (p_alert_eom) else $error("eom alert missing"); // [RULE_09]

	property p_wake_code;
		@(posedge hclk) disable iff (!hresetn)
		(state == ST_POLL && rx.wake && mode == MODE_SELF) |=>
			(woken_channel_code == $past(chan) + 2'h1) && state == ST_INIT;
	endproperty
	a_wake_code: assert property (p_wake_code) else $error("wake record wrong"); // [RULE_04]

	property p_lock_hold;
		@(posedge hclk) disable iff (!hresetn)
		(state == ST_LOCK && !rel && mode != MODE_SLEEP) |=> state == ST_LOCK;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("left lock early"); // [RULE_17]

	property p_sleep;
		@(posedge hclk) disable iff (!hresetn)
		(mode == MODE_SLEEP) |=> state == ST_SLEEP;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep ignored"); // [RULE_11]

	property p_slave_chan;
		@(posedge hclk) disable iff (!hresetn)
		(mode == MODE_SLAVE) [*2] |-> chan == 2'h0;
	endproperty
	a_slave_chan: assert property (p_slave_chan) else $error("slave scanned more"); // [RULE_03]

	property p_cycle_init;
		@(posedge hclk) disable iff (!hresetn)
		(state == ST_INIT && cmc_zero[BIT_INIT_CYCLE]) |=> fifo_clr;
	endproperty
	a_cycle_init: assert property (p_cycle_init) else $error("no cycle init"); // [RULE_14]

	property p_chan_max;
		@(posedge hclk) disable iff (!hresetn)
		chan < 2'(MAX_CHANNELS);
	endproperty
	a_chan_max: assert property (p_chan_max) else $error("channel out of range"); // [RULE_01]

	property p_no_timeout;
		@(posedge hclk) disable iff (!hresetn)
		(state == ST_WSYNC && !cmc_zero[BIT_TO_EN] && mode == MODE_SELF && !rx.sync_ok)
			|=> state == ST_WSYNC;
	endproperty
	a_no_timeout: assert property (p_no_timeout) else $error("timer while disabled"); // [RULE_15]
endmodule // spr_ctrl

// [logic/spr_fifo.sv]
// small synchronous fifo with registered read data
`timescale 1ns/1ps
module spr_fifo #(
	parameter int W = 8,
	parameter int D = 32
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0]  mem [D];
	logic [AW:0]   wp;
	logic [AW:0]   rp;
	localparam logic [AW+1:0] DEPTH = D[AW+1:0];
	logic [AW+1:0] fill;
	logic          full;
	logic          empty;
	logic          do_rd;

	// the output register holds a word too, so storage plus it must not pass D
	assign fill     = {1'b0, wp - rp} + {{(AW+1){1'b0}}, out_valid};
	assign full     = (fill >= DEPTH);
	assign empty    = (wp == rp);
	assign in_ready = !full && !clr;
	// output register counts as a slot: pop into it when free
	assign do_rd    = !empty && (!out_valid || out_ready) && !clr;

	// storage write
	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem[wp[AW-1:0]] <= in_data;
		end
	end

	// pointers and output register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp        <= '0;
			rp        <= '0;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else if (clr) begin
			wp        <= '0;
			rp        <= '0;
			out_valid <= 1'b0;
		end else begin
			if (in_valid && in_ready) begin
				wp <= wp + 1'b1;
			end
			if (do_rd) begin
				rp        <= rp + 1'b1;
				out_data  <= mem[rp[AW-1:0]];
				out_valid <= 1'b1;
			end else if (out_ready) begin
				out_valid <= 1'b0;
			end
		end
	end
endmodule // spr_fifo

// [logic/spr_pkg.sv]
// package of register map, field layout and timing for self-poll run control
package spr_pkg;
	// register indices (printed offsets, byte address = index * 4)
	localparam logic [7:0] IDX_CMC_ZERO  = 8'h02;
	localparam logic [7:0] IDX_CMC_ONE   = 8'h03;
	localparam logic [7:0] IDX_A_MODT    = 8'h11;
	localparam logic [7:0] IDX_A_PLL1    = 8'h22;
	localparam logic [7:0] IDX_A_PLL2    = 8'h23;
	localparam logic [7:0] IDX_A_PLL3    = 8'h24;
	localparam logic [7:0] IDX_B_MODT    = 8'h42;
	localparam logic [7:0] IDX_B_PLL1    = 8'h43;
	localparam logic [7:0] IDX_B_PLL2    = 8'h44;
	localparam logic [7:0] IDX_B_PLL3    = 8'h45;
	localparam logic [7:0] IDX_WOKEN     = 8'h50;
	localparam logic [7:0] IDX_MODE      = 8'h51;
	localparam logic [7:0] IDX_STATUS    = 8'h52;
	// reset values
	localparam logic [7:0] RST_CMC_ZERO  = 8'h40;
	localparam logic [7:0] RST_CMC_ONE   = 8'h00;
	localparam logic [7:0] RST_MODT      = 8'h04;
	localparam logic [7:0] RST_PLL1      = 8'h29;
	localparam logic [7:0] RST_PLL2      = 8'h08;
	localparam logic [7:0] RST_PLL3      = 8'h0a;
	// field positions
	localparam int BIT_INIT_CYCLE   = 7;
	localparam int BIT_TO_EN        = 5;
	localparam int BIT_FIFO_LOCK    = 4;
	localparam int BIT_INIT_FRAME   = 3;
	localparam int CNT_HI           = 3;
	localparam int CNT_LO           = 2;
	localparam logic [1:0] CNT_MIN  = 2'h1;
	localparam int MAX_CHANNELS     = 3;
	// host mode commands
	localparam logic [1:0] MODE_SLEEP = 2'h0;
	localparam logic [1:0] MODE_SLAVE = 2'h1;
	localparam logic [1:0] MODE_SELF  = 2'h2;
	// sync timeout in microseconds at 25 MHz
	localparam int SYS_MHZ          = 25;
	localparam int SYNC_TO_US       = 100;
	localparam int SYNC_TO_CYC      = SYNC_TO_US * SYS_MHZ;
	localparam int CHAN_DWELL_CYC   = 16;
	localparam int FIFO_W           = 8;
	localparam int FIFO_D           = 32;

	typedef enum logic [6:0] {
		ST_SLEEP = 7'h01,
		ST_POLL  = 7'h02,
		ST_INIT  = 7'h04,
		ST_WSYNC = 7'h08,
		ST_WTSI  = 7'h10,
		ST_FRAME = 7'h20,
		ST_LOCK  = 7'h40
	} spr_state_e;

	// rf tuning word for the selected channel
	typedef struct packed {
		logic       conf_b;
		logic [1:0] chan;
		logic [2:0] r_div;
		logic [1:0] s_div;
	} spr_tune_s;

	// receive stream events from the framer
	typedef struct packed {
		logic wake;
		logic sync_ok;
		logic frame_start_pattern;
		logic mid_match;
		logic end_of_message;
		logic bit_valid;
		logic bit_data;
	} spr_rx_s;
endpackage

// [testbench/spr_framer_model.sv]
// framer-side model that drives receive events into the controller
`timescale 1ns/1ps
module spr_framer_model
	import spr_pkg::*;
(
	input  wire logic hclk,
	output spr_rx_s   rx
);
	initial begin
		rx = '0;
	end

	// one-cycle event pulse, then the line drops back to idle low
	task automatic ev(input int k);
		@(posedge hclk);
		rx[k] <= 1'b1;
		@(posedge hclk);
		rx[k] <= 1'b0;
	endtask

	// symbol sync is a level held while the framer is locked on
	task automatic sync(input logic v);
		@(posedge hclk);
		rx.sync_ok <= v;
	endtask

	// random frame bits; data toggles while not valid so stale values never pass
	task automatic bits(input int n, ref logic q[$]);
		logic b;
		for (int i = 0; i < n; i++) begin
			b = 1'($urandom);
			@(posedge hclk);
			rx.bit_data  <= b;
			rx.bit_valid <= 1'b1;
			q.push_back(b);
			@(posedge hclk);
			rx.bit_data  <= ~b;
			rx.bit_valid <= 1'b0;
		end
	endtask
endmodule // spr_framer_model

// [testbench/tb_top.sv]
// self-checking bench for the self-poll run controller
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
	import spr_pkg::*;
	logic        hclk, hresetn, hsel, hwrite, hready, lock_rel, out_ready;
	logic        hreadyout, hresp, a_frame, a_mid, a_eom, out_valid, overrun;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [7:0]  out_data;
	spr_rx_s     rx;
	spr_tune_s   tune;
	logic        q[$];
	logic        qd[$];
	logic [7:0]  pll[2][3];
	int          miscompares, n_checks, got, maxc;

	assign hready = hreadyout;

	// 25 MHz system clock
	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	spr_ctrl spr_ctrl_i (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx), .fifo_lock_release(lock_rel),
		.tune(tune), .alert_frame(a_frame), .alert_mid(a_mid), .alert_eom(a_eom),
		.fifo_out_valid(out_valid), .fifo_out_ready(out_ready), .fifo_out_data(out_data),
		.fifo_overrun(overrun)
	);

	spr_framer_model spr_framer_model_i (
		.hclk(hclk),
		.rx(rx)
	);

	// single transfer; each phase is held until hready is seen high
	task automatic ahb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= {22'h0, idx, 2'b00};
		htrans <= 2'b10;
		hwrite <= w;
		hsize  <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		// idle: select and address are don't-care, upper data bits ignored
		hsel   <= 1'($urandom);
		haddr  <= $urandom;
		htrans <= 2'b00;
		hwdata <= {24'($urandom), wd};
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	// alerts are one-cycle pulses, so every cycle is looked at
	task automatic wait_alert(input int k);
		logic [2:0] a;
		got = 0;
		for (int i = 0; i < 20 && got == 0; i++) begin
			@(negedge hclk);
			a = {a_eom, a_mid, a_frame};
			if (a[k] === 1'b1) got = 1;
		end
	endtask

	function automatic logic [4:0] exp_tune(input logic b, input logic [1:0] c);
		return pll[b][c][4:0];
	endfunction

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// hang guard, well beyond the sync timeout span
	initial begin
		repeat (20000) @(posedge hclk);
		miscompares++;
		wrap_up();
	end

	initial begin
		hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
		hsize = 3'h2; hwdata = '0; lock_rel = 1'b0; out_ready = 1'b0;
		miscompares = 0;
		n_checks = 0;
		void'($urandom(32'h92844c93));
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		// reset view: nothing woken, asleep, write-only and unmapped read as zero
		ahb(0, IDX_WOKEN, 8'h0);
		`CHK("woken", 32'h0, rd)
		ahb(0, IDX_STATUS, 8'h0);
		`CHK("status", ST_SLEEP, rd[6:0])
		ahb(0, IDX_CMC_ZERO, 8'h0);
		`CHK("wo read", 32'h0, rd)
		ahb(0, 8'h7f, 8'h0);
		`CHK("unmapped", 32'h0, rd)
		// random dividers; A scans three channels, B only the minimum of one
		for (int b = 0; b < 2; b++) begin
			for (int c = 0; c < 3; c++) begin
				pll[b][c] = {3'h0, 5'($urandom)};
				ahb(1, (b ? IDX_B_PLL1 : IDX_A_PLL1) + 8'(c), pll[b][c]);
			end
		end
		ahb(1, IDX_A_MODT, 8'h0c);
		ahb(1, IDX_B_MODT, 8'h04);
		ahb(1, IDX_CMC_ZERO, 8'h90);
		ahb(1, IDX_MODE, {6'h0, MODE_SELF});
		maxc = 0;
		repeat (200) begin
			@(negedge hclk);
			`CHK("tune", exp_tune(tune.conf_b, tune.chan), {tune.r_div, tune.s_div})
			if (tune.conf_b === 1'b1) `CHK("chan b", 2'h0, tune.chan)
			else if (tune.chan > maxc) maxc = tune.chan;
		end
		`CHK("chan a max", 2, maxc)
		// wake while the third channel of A is tuned
		got = 0;
		for (int i = 0; i < 200 && got == 0; i++) begin
			@(negedge hclk);
			if (tune.conf_b === 1'b0 && tune.chan === 2'h2) got = 1;
		end
		spr_framer_model_i.ev(6);
		repeat (8) @(posedge hclk);
		ahb(0, IDX_WOKEN, 8'h0);
		`CHK("woken code", 32'h3, rd)
		ahb(0, IDX_STATUS, 8'h0);
		`CHK("run state", ST_WSYNC, rd[6:0])
		// first frame, sink stalled until the fifo overflows
		spr_framer_model_i.sync(1'b1);
		spr_framer_model_i.ev(4);
		wait_alert(0);
		`CHK("frame alert", 1, got)
		spr_framer_model_i.ev(3);
		wait_alert(1);
		`CHK("mid alert", 1, got)
		spr_framer_model_i.bits(FIFO_D + 1, q);
		repeat (6) @(posedge hclk);
		`CHK("overrun", 1'b1, overrun)
		spr_framer_model_i.ev(2);
		wait_alert(2);
		`CHK("eom alert", 1, got)
		ahb(0, IDX_STATUS, 8'h0);
		`CHK("lock flag", 1'b1, rd[7])
		`CHK("lock state", ST_LOCK, rd[6:0])
		// drain the locked frame; afterwards bits sent under lock must not enter
		got = 0;
		repeat (400) begin
			@(posedge hclk);
			if (out_valid === 1'b1 && out_ready === 1'b1) begin
				`CHK("fifo bit", q[got], out_data[0])
				got++;
			end
			out_ready <= 1'($urandom);
		end
		@(posedge hclk);
		out_ready <= 1'b0;
		spr_framer_model_i.bits(4, qd);
		repeat (6) @(posedge hclk);
		`CHK("locked fifo", 1'b0, out_valid)
		`CHK("fifo count", FIFO_D, got)
		// release, then a later frame with no new wake-up; frame-start init clears overrun
		lock_rel <= 1'b1;
		ahb(1, IDX_CMC_ONE, 8'h08);
		lock_rel <= 1'b0;
		repeat (6) @(posedge hclk);
		spr_framer_model_i.ev(4);
		wait_alert(0);
		`CHK("next frame", 1, got)
		repeat (4) @(posedge hclk);
		`CHK("frame init", 1'b0, overrun)
		// slave run keeps one channel whatever the count says
		ahb(1, IDX_MODE, {6'h0, MODE_SLAVE});
		spr_framer_model_i.sync(1'b0);
		repeat (4) @(posedge hclk);
		repeat (100) begin
			@(negedge hclk);
			`CHK("slave chan", 2'h0, tune.chan)
		end
		ahb(1, IDX_MODE, {6'h0, MODE_SLEEP});
		ahb(0, IDX_STATUS, 8'h0);
		`CHK("sleep", ST_SLEEP, rd[6:0])
		// timeout enabled, wake-up but sync never comes
		ahb(1, IDX_CMC_ZERO, 8'h20);
		ahb(1, IDX_MODE, {6'h0, MODE_SELF});
		spr_framer_model_i.ev(6);
		repeat (SYNC_TO_CYC - 100) @(posedge hclk);
		ahb(0, IDX_STATUS, 8'h0);
		`CHK("before timeout", ST_WSYNC, rd[6:0])
		repeat (200) @(posedge hclk);
		ahb(0, IDX_STATUS, 8'h0);
		`CHK("after timeout", ST_POLL, rd[6:0])
		wrap_up();
	end
endmodule // tb_top
